// file: rtl/external_pin_interrupt.sv
// External request pin detector with an APB slave register file: one
// status and control byte, plus sticky event bits with a mask and a level
// interrupt line.
// Assumes one clock pclk (20 MHz), asynchronous active-low presetn, an
// asynchronous request pin that is synchronised here, and an APB master
// that keeps every transfer word aligned.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "pin_irq_cfg.svh"

module external_pin_interrupt
  import pin_irq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        request_pin,
  output logic             pull_enable,
  output logic             pin_interrupt,
  output logic             irq
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------

  // Address decode, shared by the write path and the read path
  function automatic reg_sel_t decode(input logic [11:0] addr);
    case (addr)
      `OFS_STATUS_CONTROL: decode = sel_control;
      `OFS_EVENT_STATUS:   decode = sel_status;
      `OFS_EVENT_MASK:     decode = sel_mask;
      default:             decode = sel_none;
    endcase
  endfunction

  // Pin level mapped to "asserted" under the chosen polarity
  function automatic logic asserted_level(input logic lvl, input logic pol);
    asserted_level = pol ? lvl : ~lvl;
  endfunction

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  logic                  detection_mode;
  logic                  interrupt_enable_bit;
  logic                  request_flag;
  logic                  pin_function_enable;
  logic                  polarity_select;
  logic                  pull_device_disable;
  logic [`EVT_WIDTH-1:0] event_status;
  logic [`EVT_WIDTH-1:0] event_mask;

  // Reset image of the control byte, split into its fields below
  localparam logic [7:0] CONTROL_RESET = `RESET_STATUS_CONTROL;

  // Pin synchroniser: three stages, a change counts when 2nd and 3rd agree
  logic       sync_meta;
  logic       sync_a;
  logic       sync_b;
  logic       pin_level;
  logic       pin_level_prev;
  logic       pin_enable_prev;

  // Bus strobes
  logic       access;
  logic       setup_phase;
  logic       wr;
  logic       rd;
  reg_sel_t   sel;
  logic       wr_lane0;
  logic       mask_write;
  logic       ack_write;

  // Detection
  logic       pin_asserted;
  logic       edge_event;
  logic       level_hold;
  logic       enable_rise;
  logic       set_flag;
  logic       next_request_flag;
  logic [7:0] control_view;

  // -----------------------------------------------------------------------
  // Bus strobes
  // -----------------------------------------------------------------------

  // Every write lands at the single access edge, where ready is high
  assign access      = psel & penable;
  assign setup_phase = psel & ~penable;
  assign wr          = access & pwrite;
  assign rd          = access & ~pwrite;
  assign sel         = decode(paddr);
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign wr_lane0    = wr & pstrb[0] & (sel == sel_control);
  assign mask_write  = wr & pstrb[0] & (sel == sel_mask);
  assign ack_write   = wr_lane0 & pwdata[`BIT_ACKNOWLEDGE];

  // -----------------------------------------------------------------------
  // Pin synchronisation
  // -----------------------------------------------------------------------

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 1'b1;
      sync_a    <= 1'b1;
      sync_b    <= 1'b1;
    end else begin
      sync_meta <= request_pin;
      sync_a    <= sync_meta;
      sync_b    <= sync_a;
    end
  end

  // Filtered level only moves when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= 1'b1;
    end else if (sync_a == sync_b) begin
      pin_level <= sync_b;
    end
  end

  // Previous filtered level; reset to the pulled-up idle so that no false
  // edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_prev <= 1'b1;
    end else begin
      pin_level_prev <= pin_level;
    end
  end

  // -----------------------------------------------------------------------
  // Event detection
  // -----------------------------------------------------------------------

  // Edge is judged against the previous filtered level under current polarity
  assign pin_asserted = asserted_level(pin_level, polarity_select);
  assign edge_event   = pin_function_enable & pin_asserted &
                        ~asserted_level(pin_level_prev, polarity_select);
  assign level_hold   = pin_function_enable & detection_mode &
                        pin_asserted;
  assign enable_rise  = pin_function_enable & ~pin_enable_prev;
  // A disabled pin raises no flag, though its level changes still set event bit 1
  assign set_flag     = edge_event | level_hold | enable_rise;

  // Last enable, so that turning the pin on is seen exactly once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_enable_prev <= 1'b0;
    end else begin
      pin_enable_prev <= pin_function_enable;
    end
  end

  // -----------------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------------

  // Bit 7 has no storage; acknowledge has no storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detection_mode       <= CONTROL_RESET[`BIT_DETECTION_MODE];
      interrupt_enable_bit <= CONTROL_RESET[`BIT_INTERRUPT_ENABLE];
      pin_function_enable  <= CONTROL_RESET[`BIT_PIN_ENABLE];
      polarity_select      <= CONTROL_RESET[`BIT_POLARITY];
      pull_device_disable  <= CONTROL_RESET[`BIT_PULL_DISABLE];
    end else if (wr_lane0) begin
      detection_mode       <= pwdata[`BIT_DETECTION_MODE];
      interrupt_enable_bit <= pwdata[`BIT_INTERRUPT_ENABLE];
      pin_function_enable  <= pwdata[`BIT_PIN_ENABLE];
      polarity_select      <= pwdata[`BIT_POLARITY];
      pull_device_disable  <= pwdata[`BIT_PULL_DISABLE];
    end
  end

  // -----------------------------------------------------------------------
  // Request flag
  // -----------------------------------------------------------------------

  // Set beats acknowledge so that an event in the write cycle is not lost;
  // in level mode this also keeps the flag up while the pin is asserted
  always_comb begin
    next_request_flag = request_flag;
    if (ack_write) begin
      next_request_flag = 1'b0;
    end
    if (set_flag) begin
      next_request_flag = 1'b1;
    end
  end

  // Flag register, read-only to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_flag <= 1'b0;
    end else begin
      request_flag <= next_request_flag;
    end
  end

  // -----------------------------------------------------------------------
  // Event status (sticky, cleared by reading) and event mask
  // -----------------------------------------------------------------------
  logic [`EVT_WIDTH-1:0] evt_in;
  logic [`EVT_WIDTH-1:0] next_event_status;
  logic                  status_read;

  // Bit 0: flag newly raised; bit 1: filtered pin level moved
  assign evt_in      = {(pin_level != pin_level_prev),
                        set_flag & ~request_flag};
  assign status_read = rd & (sel == sel_status);

  // The read clears only the bits it returned: read data was captured at
  // setup, so an event landing in the setup cycle survives to the next read
  always_comb begin
    next_event_status = event_status | evt_in;
    if (status_read) begin
      next_event_status = (event_status & ~prdata[`EVT_WIDTH-1:0]) | evt_in;
    end
  end

  // Sticky event bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= '0;
    end else begin
      event_status <= next_event_status;
    end
  end

  // Event mask, written through byte lane 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask <= `RESET_EVENT_MASK;
    end else if (mask_write) begin
      event_mask <= pwdata[`EVT_WIDTH-1:0];
    end
  end

  // -----------------------------------------------------------------------
  // Read data and bus answer
  // -----------------------------------------------------------------------

  // Reserved bit 7 and acknowledge bit 2 always read zero
  always_comb begin
    control_view = 8'h00;
    control_view[`BIT_DETECTION_MODE]   = detection_mode;
    control_view[`BIT_INTERRUPT_ENABLE] = interrupt_enable_bit;
    control_view[`BIT_REQUEST_FLAG]     = request_flag;
    control_view[`BIT_PIN_ENABLE]       = pin_function_enable;
    control_view[`BIT_POLARITY]         = polarity_select;
    control_view[`BIT_PULL_DISABLE]     = pull_device_disable;
  end

  // Ready answers in the first access cycle only; a pulse, never held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Unmapped offsets are refused in the same cycle as ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & (sel == sel_none);
    end
  end

  // Read data captured at setup, so it stands for the whole access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      case (sel)
        sel_control: prdata <= {24'h00_0000, control_view};
        sel_status:  prdata <= {30'h0000_0000, event_status};
        sel_mask:    prdata <= {30'h0000_0000, event_mask};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Pin side outputs and interrupts
  // -----------------------------------------------------------------------

  // Pull is on only for an enabled falling-polarity pin not told to drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_enable <= 1'b0;
    end else begin
      pull_enable <= pin_function_enable & ~pull_device_disable &
                     ~polarity_select;
    end
  end

  // Polled or interrupting: the enable bit gates the flag onto the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_interrupt <= 1'b0;
    end else begin
      pin_interrupt <= interrupt_enable_bit & request_flag;
    end
  end

  // Level interrupt from the sticky event bits that are not masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

endmodule

// file: rtl/pin_irq_cfg.svh
// Offsets, field positions and reset values of the pin request block.
// Assumes inclusion by bare name from the package or the design module.
`ifndef PIN_IRQ_CFG_SVH
`define PIN_IRQ_CFG_SVH

// -----------------------------------------------------------------------
// Register map (byte addresses on APB)
// -----------------------------------------------------------------------
`define OFS_STATUS_CONTROL   12'h000
`define OFS_EVENT_STATUS     12'h004
`define OFS_EVENT_MASK       12'h008

// -----------------------------------------------------------------------
// Fields of the status and control register
// -----------------------------------------------------------------------
`define BIT_DETECTION_MODE   0
`define BIT_INTERRUPT_ENABLE 1
`define BIT_ACKNOWLEDGE      2
`define BIT_REQUEST_FLAG     3
`define BIT_PIN_ENABLE       4
`define BIT_POLARITY         5
`define BIT_PULL_DISABLE     6
`define BIT_RESERVED         7
`define RESET_STATUS_CONTROL 8'h00

// -----------------------------------------------------------------------
// Event status and mask layout
// -----------------------------------------------------------------------
`define EVT_FLAG_SET         0
`define EVT_PIN_CHANGE       1
`define EVT_WIDTH            2
`define RESET_EVENT_MASK     2'h0

`endif

// file: rtl/pin_irq_pkg.sv
// Types shared by the pin request block.
// Assumes the constants header sits beside it in rtl/.
package pin_irq_pkg;

  // Decoded register selected by an APB address
  typedef enum logic [1:0] {
    sel_none    = 2'b00,
    sel_control = 2'b01,
    sel_status  = 2'b10,
    sel_mask    = 2'b11
  } reg_sel_t;

endpackage

// file: test/pin_source_model.sv
// Behavioural request source that drives the external request pin.
// Assumes the internal pull device pulls the pin high when it is on.
`timescale 1ns/1ps
module pin_source_model (
  input  wire logic drive,
  input  wire logic level,
  input  wire logic pull_enable,
  output logic      pin
);
  logic last = 1'b1;
  // Released pin: pull level, else inverse of last value so no stale match
  always_comb pin = drive ? level : (pull_enable ? 1'b1 : ~last);
  // Remember the last driven level
  always @(level) if (drive) last = level;
endmodule

// file: test/pin_irq_monitor.sv
// Concurrent checks on the ports of the pin request block.
// Assumes it is bound into external_pin_interrupt below.
`timescale 1ns/1ps
module pin_irq_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pull_enable,
  input wire logic        pin_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read answer of the control register
  wire rd0 = pready && !pwrite && paddr == 12'h000 && !pslverr;
  answer_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_unmapped_a: assert property (psel && !penable && paddr > 12'h008
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  reserved_zero_a: assert property (rd0 |-> !prdata[7])
    else $error("reserved bit set");
  ack_zero_a: assert property (rd0 |-> !prdata[2])
    else $error("acknowledge bit read as one");
  irq_out_a: assert property (rd0 |-> pin_interrupt ==
    (prdata[1] & prdata[3])) else $error("interrupt not flag and enable");
  pull_ctrl_a: assert property (rd0 |-> pull_enable ==
    (prdata[4] & !prdata[5] & !prdata[6])) else $error("pull control");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind external_pin_interrupt pin_irq_monitor i_mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pull_enable,
  .pin_interrupt);

// file: test/tb.sv
// Self-checking bench for the pin request block over APB.
// Assumes the design, its package and the source model are compiled first.
`timescale 1ns/1ps
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, pull_enable, pin_interrupt, irq, pin, er;
  logic        drive = 1, level = 1;
  int          fails = 0, check_count = 0, seed = 32'h5ed9897f;
  // Clock, 50 ns period
  always #25 pclk = ~pclk;
  external_pin_interrupt i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .request_pin(pin), .pull_enable, .pin_interrupt, .irq);
  pin_source_model i_src (.drive, .level, .pull_enable, .pin);
  task automatic complete_run;
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, then access until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      fails++;
      $display("MISMATCH %0t no ready", $time);
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    xfer(0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  // Move the pin and let it cross the synchroniser
  task automatic pin_to(input logic l);
    level <= l;
    repeat (8) @(posedge pclk);
  endtask
  // Watchdog, far beyond the expected run length
  initial begin
    #(20000 * 50);
    fails++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rchk(12'h000, 8'h00);
    xfer(0, 12'h0fc, 8'h00); chk(er, 1);
    xfer(1, 12'h000, 8'h84); rchk(12'h000, 8'h00);
    xfer(1, 12'h000, 8'h10); rchk(12'h000, 8'h18);
    chk(pull_enable, 1);
    xfer(1, 12'h000, 8'h14); rchk(12'h000, 8'h10);
    pin_to(0); rchk(12'h000, 8'h18);
    xfer(1, 12'h000, 8'h16); rchk(12'h000, 8'h12);
    pin_to(1); pin_to(0); rchk(12'h000, 8'h1a);
    chk(pin_interrupt, 1);
    xfer(1, 12'h000, 8'h17); rchk(12'h000, 8'h1b);
    pin_to(1); xfer(1, 12'h000, 8'h17); rchk(12'h000, 8'h13);
    chk(pin_interrupt, 0);
    pin_to(0);
    xfer(1, 12'h000, 8'h34);
    rchk(12'h000, 8'h38);
    xfer(1, 12'h000, 8'h34);
    rchk(12'h000, 8'h30);
    chk(pull_enable, 0);
    pin_to(1); rchk(12'h000, 8'h38);
    xfer(1, 12'h000, 8'h54);
    @(posedge pclk);
    chk(pull_enable, 0);
    xfer(1, 12'h000, 8'h04); pin_to(0); pin_to(1);
    rchk(12'h000, 8'h00);
    // Event status, mask and the level interrupt
    xfer(1, 12'h008, 8'h01); xfer(0, 12'h004, 8'h00);
    xfer(1, 12'h000, 8'h10); repeat (3) @(posedge pclk);
    chk(irq, 1);
    xfer(1, 12'h008, 8'h00);
    @(posedge pclk);
    chk(irq, 0);
    xfer(1, 12'h008, 8'h01);
    @(posedge pclk);
    chk(irq, 1);
    xfer(0, 12'h004, 8'h00); chk(rd[0], 1);
    @(posedge pclk); chk(irq, 0);
    // Random control values; flag masked out, fixed fields checked
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      level <= v[8];
      drive <= v[9];
      xfer(1, 12'h000, v[7:0]); xfer(0, 12'h000, 8'h00);
      chk(rd & 32'hf7, {24'h0, v[7:0] & 8'h73});
    end
    complete_run;
  end
endmodule
